/* core/hcar_pkg.sv */
// constants, types and register map of the hall commutation block
// Operation
// [R1] alternate freewheel recirculation between high and low sides
// [R2] first revolution modulates highs, next modulates lows
// [R3] twelve states, wrapping from L to A
// [R4] direction 1, high modulation: phase pair table
// [R5] direction 1, low modulation: phase pair table
// [R6] direction 0, high modulation: phase pair table
// [R7] direction 0, low modulation: phase pair table
// [R8] third phase floats, both gates low
// [R9] hall codes 111 and 000 give all gates low
// [R10] freewheel select picks diode or active freewheeling
// [R11] diode freewheeling holds complemented pwm gates low
// [R12] low brake overrides, applies configured brake behaviour
// [R13] pwm input sets modulated gate duty and frequency
// [R14] dead time inserted before each gate turns on
// [R15] alternate brake swaps side on every new event
// [R16] half toggles after six hall code changes
// [R17] inputs synchronised, gate commands registered
package hcar_pkg;

	// register byte offsets
	localparam logic [3:0] CTRL_OFS     = 4'h0;
	localparam logic [3:0] DEADTIME_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS   = 4'h8;

	// control register fields
	localparam int CTRL_ENABLE_BIT    = 0;
	localparam int CTRL_FREEW_BIT     = 1;
	localparam int CTRL_BRAKE_LSB     = 2;
	localparam logic [3:0] CTRL_RESET = 4'hC;

	// dead time register fields and reset
	localparam int DEAD_TIME_RISING_LSB         = 0;
	localparam int DEAD_TIME_HALL_MODE_LSB         = 8;
	localparam int DT_WIDTH            = 8;
	localparam logic [15:0] DT_RESET   = 16'h0404;

	// status register fields
	localparam int ST_HALL_LSB   = 0;
	localparam int ST_STATE_LSB  = 3;
	localparam int ST_HALF_BIT   = 7;
	localparam int ST_BRAKE_BIT  = 8;
	localparam int ST_BSIDE_BIT  = 9;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// synchroniser reset: brake pin idles high
	localparam logic [5:0] SYNC_RESET = 6'h08;

	// hall codes that never appear on a healthy sensor set
	localparam logic [2:0] HALL_ALL_LOW  = 3'h0;
	localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

	// brake configurations
	typedef enum logic [1:0] {
		HCAR_BRAKE_LOW,
		HCAR_BRAKE_HIGH,
		HCAR_BRAKE_ALT,
		HCAR_BRAKE_HIZ
	} hcar_brake_t;

	// twelve commutation states, A..F high half, G..L low half
	typedef enum logic [3:0] {
		ST_A, ST_B, ST_C, ST_D, ST_E, ST_F,
		ST_G, ST_H, ST_I, ST_J, ST_K, ST_L
	} hcar_state_t;

	// six gate commands, index 0 = phase a
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} hcar_gate_t;

endpackage

/* core/hcar_core.sv */
// hall commutation with alternating recirculation and axi4-lite registers
`timescale 1ns/1ps
module hcar_core
#(
	parameter int SYNC_STAGES = 2
)
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// controller and sensor pins
	input  wire logic        pwm_input_i,
	input  wire logic        rotation_direction_input_i,
	input  wire logic        hall_sensor_a_i,
	input  wire logic        hall_sensor_b_i,
	input  wire logic        hall_sensor_c_i,
	input  wire logic        brake_request_n_i,
	// gate commands
	output logic             high_gate_a_o,
	output logic             low_gate_a_o,
	output logic             high_gate_b_o,
	output logic             low_gate_b_o,
	output logic             high_gate_c_o,
	output logic             low_gate_c_o,
	output logic             driver_hiz_o,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	////////////////////////////////////////////////////////////////////
	// input synchronisers
	////////////////////////////////////////////////////////////////////

	logic [5:0] sync_reg [SYNC_STAGES]; // pin synchroniser chain
	logic [5:0] pins;                   // raw pin bundle
	logic [5:0] synced;                 // last stage

	assign pins = {pwm_input_i, rotation_direction_input_i,
		brake_request_n_i, hall_sensor_a_i, hall_sensor_b_i,
		hall_sensor_c_i};
	assign synced = sync_reg[SYNC_STAGES-1];

	// chain of flops, first stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			for (int s = 0; s < SYNC_STAGES; s++)
				sync_reg[s] <= hcar_pkg::SYNC_RESET;
		else
		begin
			sync_reg[0] <= pins; // R17
			for (int s = 1; s < SYNC_STAGES; s++)
				sync_reg[s] <= sync_reg[s-1];
		end
	end

	wire       pwm      = synced[5];   // R13
	wire       dir      = synced[4];   // rotation direction
	wire       brake_n  = synced[3];   // brake request, active low
	wire [2:0] hall     = synced[2:0]; // {a,b,c}

	////////////////////////////////////////////////////////////////////
	// registers
	////////////////////////////////////////////////////////////////////

	logic [3:0]  ctrl_reg;  // enable, freewheel, brake config
	logic [15:0] dt_reg;    // dead times
	wire enable_mode = ctrl_reg[hcar_pkg::CTRL_ENABLE_BIT];
	wire freewheel_select = ctrl_reg[hcar_pkg::CTRL_FREEW_BIT];
	wire hcar_pkg::hcar_brake_t brake_cfg =
		hcar_pkg::hcar_brake_t'(ctrl_reg[hcar_pkg::CTRL_BRAKE_LSB +: 2]);
	wire [7:0] dead_time_rising =
		dt_reg[hcar_pkg::DEAD_TIME_RISING_LSB +: hcar_pkg::DT_WIDTH];
	wire [7:0] dead_time_hall_mode =
		dt_reg[hcar_pkg::DEAD_TIME_HALL_MODE_LSB +: hcar_pkg::DT_WIDTH];

	////////////////////////////////////////////////////////////////////
	// commutation state machine
	////////////////////////////////////////////////////////////////////

	hcar_pkg::hcar_state_t state_reg;  // current of twelve states
	logic [2:0]            hall_prev_reg; // last valid hall code
	logic                  brake_prev_reg; // brake level last cycle
	logic                  bside_reg;   // alternate brake high side

	wire valid_code = (hall != hcar_pkg::HALL_ALL_LOW) &&
		(hall != hcar_pkg::HALL_ALL_HIGH);
	wire brake_act = !brake_n;                       // R12
	wire brake_event = brake_act && !brake_prev_reg; // new brake
	wire step = enable_mode && !brake_act && valid_code &&
		(hall != hall_prev_reg);
	wire low_half = (state_reg >= hcar_pkg::ST_G);   // R2
	wire [3:0] state_inc = 4'(state_reg) + 4'h1;

	// advance once per hall code change, six per half
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg     <= hcar_pkg::ST_A;
			hall_prev_reg <= hcar_pkg::HALL_ALL_LOW;
		end
		else
		begin
			if (valid_code)
				hall_prev_reg <= hall;
			if (!enable_mode)
				state_reg <= hcar_pkg::ST_A;
			else if (step)
			begin
				// wrap after L, else next state
				if (state_reg == hcar_pkg::ST_L)
					state_reg <= hcar_pkg::ST_A; // R3
				else
					state_reg <= hcar_pkg::hcar_state_t'(state_inc); // R16
			end
		end
	end

	// alternate brake side flips on each new event
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			brake_prev_reg <= 1'b0;
			bside_reg      <= 1'b1;
		end
		else
		begin
			brake_prev_reg <= brake_act;
			if (brake_event && brake_cfg == hcar_pkg::HCAR_BRAKE_ALT)
				bside_reg <= !bside_reg; // R15
		end
	end

	////////////////////////////////////////////////////////////////////
	// commutation table
	////////////////////////////////////////////////////////////////////

	// pair {p,q}: high half p modulated q low on; low half p high on
	function automatic logic [3:0] hcar_pair(input logic [2:0] code,
		input logic d);
		logic [3:0] pr;
		pr = 4'h0;
		case (code)
			3'h5: pr = d ? 4'h2 : 4'h8; // a/c or c/a
			3'h4: pr = d ? 4'h6 : 4'h9; // b/c or c/b
			3'h6: pr = d ? 4'h4 : 4'h1; // b/a or a/b
			3'h2: pr = d ? 4'h8 : 4'h2; // c/a or a/c
			3'h3: pr = d ? 4'h9 : 4'h6; // c/b or b/c
			3'h1: pr = d ? 4'h1 : 4'h4; // a/b or b/a
			default: pr = 4'h0;
		endcase
		return pr;
	endfunction

	wire [3:0] pair = hcar_pair(hall, dir); // R4 R5 R6 R7
	wire [1:0] ph_p = pair[3:2];
	wire [1:0] ph_q = pair[1:0];
	wire comp_pwm = freewheel_select & ~pwm; // R10 R11
	wire bside_now = brake_event ? !bside_reg : bside_reg;
	wire brake_low = (brake_cfg == hcar_pkg::HCAR_BRAKE_LOW) ||
		(brake_cfg == hcar_pkg::HCAR_BRAKE_ALT && !bside_now);
	wire brake_high = (brake_cfg == hcar_pkg::HCAR_BRAKE_HIGH) ||
		(brake_cfg == hcar_pkg::HCAR_BRAKE_ALT && bside_now);
	wire brake_hiz = brake_act && brake_cfg == hcar_pkg::HCAR_BRAKE_HIZ;

	hcar_pkg::hcar_gate_t cmd; // wanted gate levels before dead time

	// table lookup; unused phase stays with both gates low
	always_comb
	begin
		cmd = '0; // R8 R9
		if (brake_act)
		begin
			cmd.low  = {3{brake_low}};  // R12
			cmd.high = {3{brake_high}};
		end
		else if (enable_mode && valid_code)
		begin
			if (!low_half)
			begin
				// highs modulate, return low side held on
				cmd.high[ph_p] = pwm;      // R1 R13
				cmd.low[ph_p]  = comp_pwm;
				cmd.low[ph_q]  = 1'b1;
			end
			else
			begin
				// lows modulate, return high side held on
				cmd.low[ph_q]  = pwm;      // R1 R13
				cmd.high[ph_q] = comp_pwm;
				cmd.high[ph_p] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// dead time and output flops
	////////////////////////////////////////////////////////////////////

	hcar_pkg::hcar_gate_t gate_reg; // registered gate commands
	logic                 hiz_reg;  // all switches high impedance

	for (genvar i = 0; i < 3; i++)
	begin : g_phase
		logic [7:0] hoff_reg; // cycles the high gate has been off
		logic [7:0] loff_reg; // cycles the low gate has been off
		wire h_ok = !gate_reg.low[i] && (loff_reg >= dead_time_rising);
		wire l_ok = !gate_reg.high[i] &&
			(hoff_reg >= dead_time_hall_mode);

		// turn off at once, turn on only after the partner's gap
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				gate_reg.high[i] <= 1'b0;
				gate_reg.low[i]  <= 1'b0;
				hoff_reg         <= 8'h00;
				loff_reg         <= 8'h00;
			end
			else
			begin
				gate_reg.high[i] <= cmd.high[i] && h_ok; // R14 R17
				gate_reg.low[i]  <= cmd.low[i] && l_ok;  // R14 R17
				if (gate_reg.high[i])
					hoff_reg <= 8'h00;
				else if (hoff_reg != 8'hFF)
					hoff_reg <= hoff_reg + 8'h01;
				if (gate_reg.low[i])
					loff_reg <= 8'h00;
				else if (loff_reg != 8'hFF)
					loff_reg <= loff_reg + 8'h01;
			end
		end
	end

	// high impedance brake flag
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			hiz_reg <= 1'b0;
		else
			hiz_reg <= brake_hiz; // R12
	end

	assign high_gate_a_o = gate_reg.high[0];
	assign high_gate_b_o = gate_reg.high[1];
	assign high_gate_c_o = gate_reg.high[2];
	assign low_gate_a_o  = gate_reg.low[0];
	assign low_gate_b_o  = gate_reg.low[1];
	assign low_gate_c_o  = gate_reg.low[2];
	assign driver_hiz_o  = hiz_reg;

	////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	////////////////////////////////////////////////////////////////////

	logic        awready_reg, wready_reg, bvalid_reg;
	logic        arready_reg, rvalid_reg;
	logic        aw_full_reg, w_full_reg;
	logic [3:0]  awaddr_reg;   // held write address
	logic [31:0] wdata_reg;    // held write data
	logic [3:0]  wstrb_reg;    // held byte enables
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
	wire [31:0] lane = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire [31:0] ctrl_word = {28'h0, ctrl_reg};
	wire [31:0] dt_word = {16'h0, dt_reg};
	wire [31:0] ctrl_new = (ctrl_word & ~lane) | (wdata_reg & lane);
	wire [31:0] dt_new = (dt_word & ~lane) | (wdata_reg & lane);
	wire wr_ctrl = awaddr_reg == hcar_pkg::CTRL_OFS;
	wire wr_dt = awaddr_reg == hcar_pkg::DEADTIME_OFS;
	wire wr_ro = awaddr_reg == hcar_pkg::STATUS_OFS;
	wire [31:0] status_word = {22'h0, bside_reg, brake_act, low_half,
		4'(state_reg), hall};
	wire rd_ctrl = s_axi_araddr == hcar_pkg::CTRL_OFS;
	wire rd_dt = s_axi_araddr == hcar_pkg::DEADTIME_OFS;
	wire rd_st = s_axi_araddr == hcar_pkg::STATUS_OFS;
	wire [31:0] rd_word = rd_ctrl ? ctrl_word :
		rd_dt ? dt_word : rd_st ? status_word : 32'h0;

	// write channel: address and data taken in either order
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= hcar_pkg::RESP_OKAY;
			awaddr_reg  <= 4'h0;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
			ctrl_reg    <= hcar_pkg::CTRL_RESET;
			dt_reg      <= hcar_pkg::DT_RESET;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awaddr_reg  <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (do_write)
			begin
				// store and answer; unmapped gives slave error
				if (wr_ctrl)
					ctrl_reg <= ctrl_new[3:0];
				if (wr_dt)
					dt_reg <= dt_new[15:0];
				bresp_reg <= (wr_ctrl || wr_dt || wr_ro) ?
					hcar_pkg::RESP_OKAY : hcar_pkg::RESP_SLVERR;
				bvalid_reg <= 1'b1;
			end
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// read channel: one outstanding read
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= hcar_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_reg)
		begin
			rdata_reg   <= rd_word;
			rresp_reg   <= (rd_ctrl || rd_dt || rd_st) ?
				hcar_pkg::RESP_OKAY : hcar_pkg::RESP_SLVERR;
			rvalid_reg  <= 1'b1;
			arready_reg <= 1'b0;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

endmodule

/* tb/hcar_core_sva.sv */
// concurrent checks on the hall commutation core ports
`timescale 1ns/1ps
module hcar_core_sva
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// pins
	input wire logic brake_request_n_i,
	input wire logic hall_sensor_a_i,
	input wire logic hall_sensor_b_i,
	input wire logic hall_sensor_c_i,
	// gate commands
	input wire logic high_gate_a_o,
	input wire logic low_gate_a_o,
	input wire logic high_gate_b_o,
	input wire logic low_gate_b_o,
	input wire logic high_gate_c_o,
	input wire logic low_gate_c_o,
	input wire logic driver_hiz_o,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// hall code and per-phase activity
	logic [2:0] hall;
	logic [2:0] on;
	assign hall = {hall_sensor_a_i, hall_sensor_b_i, hall_sensor_c_i};
	assign on = {high_gate_c_o | low_gate_c_o, high_gate_b_o | low_gate_b_o,
		high_gate_a_o | low_gate_a_o};
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// brake released across the whole pipeline
	sequence s_run;
		brake_request_n_i [*4];
	endsequence
	// address and data taken at one edge
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	////////////////////////////////////////////////////////////////////////
	chk_hiz_gates_off: assert property (driver_hiz_o |-> on == 3'h0)
		else $error("gate on while outputs are high impedance");
	chk_no_shoot: assert property (
		!(high_gate_a_o && low_gate_a_o) && !(high_gate_b_o && low_gate_b_o)
		&& !(high_gate_c_o && low_gate_c_o))
		else $error("both gates of one phase on");
	chk_dead_gap: assert property (
		$rose(high_gate_a_o) |-> !$past(low_gate_a_o))
		else $error("high gate a rose with no gap after its low gate");
	chk_third_float: assert property (s_run |-> on != 3'h7)
		else $error("all three phases driven outside brake");
	chk_forbid_off: assert property (
		((hall == 3'h0 || hall == 3'h7) && brake_request_n_i) [*4]
		|-> on == 3'h0)
		else $error("gate on during a forbidden hall code");
	chk_hiz_release: assert property (s_run |-> !driver_hiz_o)
		else $error("high impedance kept after brake release");
	// readies drop at the take, response rises one edge later
	chk_write_answer: assert property (s_wr_both |=> !s_axi_awready
		&& !s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late or readies still high");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after address");
endmodule

/* tb/hcar_ctrl_model.sv */
// controller and hall sensor stand-in driving the core's pins
`timescale 1ns/1ps
module hcar_ctrl_model
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// commands from the bench
	input  wire logic [2:0] hall_cmd_i,
	input  wire logic       dir_cmd_i,
	input  wire logic       brake_n_cmd_i,
	input  wire logic       pwm_cmd_i,
	// pins toward the core
	output logic            pwm_o,
	output logic            dir_o,
	output logic [2:0]      hall_o,
	output logic            brake_n_o
);
	// pins move only just after a clock edge
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pwm_o     <= 1'b0;
			dir_o     <= 1'b1;
			hall_o    <= 3'h5;
			brake_n_o <= 1'b1;
		end
		else
		begin
			pwm_o     <= pwm_cmd_i;
			dir_o     <= dir_cmd_i;
			hall_o    <= hall_cmd_i;
			brake_n_o <= brake_n_cmd_i;
		end
	end
endmodule

/* tb/hcar_core_bench.sv */
// self-checking bench for the hall commutation core
`timescale 1ns/1ps
module hcar_core_bench;
	// clock, reset and counters
	logic       clk_i;
	logic       rst_n_i;
	int         mismatches;
	int         samples_checked;
	int         cycles;
	int         steps;
	int         idx;
	// model commands and pins
	logic [2:0] hall_cmd, hall_w;
	logic       dir_cmd, brake_n_cmd, pwm_cmd, pwm_w, dir_w, brk_w;
	// gate commands as one struct
	hcar_pkg::hcar_gate_t gates;
	logic       hiz;
	// register bus
	logic       awvalid, awready, wvalid, wready, bvalid, bready;
	logic       arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	// hall codes of one electrical revolution
	logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

	hcar_ctrl_model ctl (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.hall_cmd_i(hall_cmd), .dir_cmd_i(dir_cmd), .pwm_cmd_i(pwm_cmd),
		.brake_n_cmd_i(brake_n_cmd), .pwm_o(pwm_w), .dir_o(dir_w),
		.hall_o(hall_w), .brake_n_o(brk_w));
	hcar_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwm_input_i(pwm_w),
		.rotation_direction_input_i(dir_w), .hall_sensor_a_i(hall_w[2]),
		.hall_sensor_b_i(hall_w[1]), .hall_sensor_c_i(hall_w[0]),
		.brake_request_n_i(brk_w), .high_gate_a_o(gates.high[0]),
		.low_gate_a_o(gates.low[0]), .high_gate_b_o(gates.high[1]),
		.low_gate_b_o(gates.low[1]), .high_gate_c_o(gates.high[2]),
		.low_gate_c_o(gates.low[2]), .driver_hiz_o(hiz),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// four pipeline edges plus the reset dead time
	task automatic settle();
		repeat (12) @(posedge clk_i);
	endtask
	// one register write, held until each channel is taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_i);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		forever
		begin
			@(posedge clk_i);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	// one register read
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_i);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		forever
		begin
			@(posedge clk_i);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	// control register write expecting okay
	task automatic ctrl(input logic [3:0] v);
		logic [1:0] r;
		wr(hcar_pkg::CTRL_OFS, {28'h0000000, v}, r);
		check(r, hcar_pkg::RESP_OKAY);
	endtask
	// expected gates from hall code, direction, half, pwm, freewheel
	function automatic hcar_pkg::hcar_gate_t exp_g(input logic [2:0] h,
		input logic d, input logic lo, input logic p, input logic act);
		logic [3:0] pr;
		hcar_pkg::hcar_gate_t g;
		g = '0;
		case (h)
			3'h5: pr = 4'h2;
			3'h4: pr = 4'h6;
			3'h6: pr = 4'h4;
			3'h2: pr = 4'h8;
			3'h3: pr = 4'h9;
			3'h1: pr = 4'h1;
			default: return g;
		endcase
		if (!d)
			pr = {pr[1:0], pr[3:2]};
		if (!lo)
		begin
			g.high[pr[3:2]] = p;
			g.low[pr[3:2]]  = act & ~p;
			g.low[pr[1:0]]  = 1'b1;
		end
		else
		begin
			g.low[pr[1:0]]  = p;
			g.high[pr[1:0]] = act & ~p;
			g.high[pr[3:2]] = 1'b1;
		end
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset values and unmapped offset
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rd(hcar_pkg::CTRL_OFS, d, r);
		check(d, 32'h0000000C);
		rd(hcar_pkg::DEADTIME_OFS, d, r);
		check(d, 32'h00000404);
		rd(4'hC, d, r);
		check(r, hcar_pkg::RESP_SLVERR);
		wr(4'hC, 32'hFFFFFFFF, r);
		check(r, hcar_pkg::RESP_SLVERR);
	endtask
	// one brake event under a given control value
	task automatic brake_ev(input logic [3:0] cv, input logic [5:0] e,
		input logic hz);
		ctrl(cv);
		brake_n_cmd <= 1'b0;
		settle();
		check(gates, e);
		check(hiz, hz);
		brake_n_cmd <= 1'b1;
		settle();
	endtask
	// hold one hall state and try both pwm levels
	task automatic step_chk(input logic d, input logic act);
		logic lo;
		lo = 1'((steps / 6) % 2);
		dir_cmd <= d;
		for (int p = 0; p < 2; p++)
		begin
			pwm_cmd <= 1'(p);
			settle();
			check(gates, exp_g(seq[idx], d, lo, 1'(p), act));
		end
	endtask
	// advance the hall code n times
	task automatic walk(input int n, input logic d, input logic act);
		for (int i = 0; i < n; i++)
		begin
			idx = (idx + 1) % 6;
			steps++;
			hall_cmd <= seq[idx];
			step_chk(d, act);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			summarize();
		end
	end
	// main sequence
	initial
	begin
		{mismatches, samples_checked, cycles, steps, idx} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		hall_cmd = 3'h5;
		{dir_cmd, brake_n_cmd, pwm_cmd} = 3'h6;
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		brake_ev(4'h9, 6'h07, 1'b0);
		brake_ev(4'h9, 6'h38, 1'b0);
		brake_ev(4'h1, 6'h07, 1'b0);
		brake_ev(4'h5, 6'h38, 1'b0);
		brake_ev(4'hD, 6'h00, 1'b1);
		ctrl(4'h3);
		step_chk(1'b1, 1'b1);
		walk(12, 1'b1, 1'b1);
		hall_cmd <= 3'h7;
		settle();
		check(gates, 6'h00);
		hall_cmd <= 3'h0;
		settle();
		check(gates, 6'h00);
		ctrl(4'h1);
		walk(12, 1'b0, 1'b0);
		ctrl(4'h0);
		settle();
		check(gates, 6'h00);
		summarize();
	end
endmodule

bind hcar_core hcar_core_sva chk (.*);
